// [common/hsq_consts.vh]
// constants for the heater stabilization qualifier: offsets, fields, resets, timing
// assumes a 40 MHz clock and a 32-bit AXI4-Lite register bus
//
// Summary of operation
// - host writes temperature, held, clamped to range
// - auto scroll steps display every 5 s
// - derive resistance, power; compute both change rates
// - deterioration alarm from reference rate, two levels
// - separate alarm from last change rate
// - capture reference resistance once stable
// - two states; stabilized lamp only when stabilized
// - alarms evaluated only while stabilized
// - enter stabilized on all four, no error
// - power mode cond one uses larger count
// - temperature mode cond one uses resistance count
// - power mode cond two uses larger count
// - temperature mode cond two uses resistance count
// - deviation rate is R/ref*100-100 percent
// - cond three: voltage at least lower limit
// - no-input lamp while voltage, current absent
// - cond four: current at least lower limit
// - leave stabilized when any condition fails
// - measurement error forces waiting state
`ifndef HSQ_CONSTS_VH
`define HSQ_CONSTS_VH

`define HSQ_ADDR_CTRL 8'h00
`define HSQ_ADDR_COUNTS 8'h04
`define HSQ_ADDR_VLIM 8'h08
`define HSQ_ADDR_ILIM 8'h0C
`define HSQ_ADDR_PBAND 8'h10
`define HSQ_ADDR_TEMP 8'h14
`define HSQ_ADDR_TBAND 8'h18
`define HSQ_ADDR_DEV 8'h1C
`define HSQ_ADDR_LEVELS 8'h20
`define HSQ_ADDR_LASTLVL 8'h24
`define HSQ_ADDR_STATUS 8'h28
`define HSQ_ADDR_RATES 8'h2C
`define HSQ_ADDR_MEAS 8'h30

`define HSQ_CTRL_TEMPMODE 0
`define HSQ_CTRL_SCROLL 1

`define HSQ_RST_COUNTS 32'h00000A0A
`define HSQ_RST_LEVELS_W 32'h0032001E
`define HSQ_RST_PBAND 32'h00000014
`define HSQ_RST_DEV 32'h00140000
`define HSQ_RST_LASTLVL 32'h000003E8

`define HSQ_TEMP_MIN (-1999)
`define HSQ_TEMP_MAX 9999
`define HSQ_RATE_ONE 1000
`define HSQ_RATE_CAP 10999

`define HSQ_SCROLL_S 5
`define HSQ_CLK_HZ 40000000
`define HSQ_SCROLL_ITEMS 6

`define HSQ_RESP_OKAY 2'b00
`define HSQ_RESP_SLVERR 2'b10

`endif

// [logic/hsq_run_counter.v]
// consecutive in-band counter for one stabilization condition
// assumes step is a one-cycle pulse per calculation cycle
`timescale 1ns/1ps
module hsq_run_counter
(
  input wire clk,
  input wire sys_rst,
  input wire ce,
  input wire step,
  input wire inBand,
  input wire [7:0] target,
  output reg met
);
  reg [7:0] cnt_r;
  wire [7:0] cnt_nxt = (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_r <= 8'h00;
      met <= 1'b0;
    end
    else if (ce && step)
    begin
      if (!inBand)
      begin
        cnt_r <= 8'h00;
        met <= 1'b0;
      end
      else
      begin
        cnt_r <= cnt_nxt;
        met <= (cnt_nxt >= target);
      end
    end
  end
endmodule // hsq_run_counter

// [logic/hsq_axil_port.v]
// AXI4-Lite slave front end: one write and one read at a time
// assumes the top decodes addresses combinationally and accepts wrEn pulses
`timescale 1ns/1ps
`include "hsq_consts.vh"
module hsq_axil_port
(
  input wire clk,
  input wire sys_rst,
  input wire ce,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg wrEn,
  output reg [7:0] wrAddr,
  output reg [31:0] wrData,
  output reg [3:0] wrStrb,
  input wire wrOk,
  input wire [31:0] rdData,
  input wire rdOk
);
  reg awHeld_r;
  reg wHeld_r;

  assign s_axi_awready = ce && !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = ce && !wHeld_r && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      wrEn <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 32'h00000000;
      wrStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HSQ_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `HSQ_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else if (ce)
    begin
      wrEn <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_r <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_r <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
      // both halves held: commit once, raising bvalid and, only when wrOk is set, wrEn on the next edge
      if (awHeld_r && wHeld_r && !s_axi_bvalid)
      begin
        wrEn <= wrOk;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? `HSQ_RESP_OKAY : `HSQ_RESP_SLVERR;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdOk ? rdData : 32'h00000000;
        s_axi_rresp <= rdOk ? `HSQ_RESP_OKAY : `HSQ_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // hsq_axil_port

// [logic/hsq_qualifier.v]
// heater stabilization qualifier: state machine, change rates, alarms, registers
// assumes measStrobe pulses once per calculation cycle with voltage/current valid
`timescale 1ns/1ps
`include "hsq_consts.vh"
module hsq_qualifier
#(
  parameter [31:0] SCROLL_CYCLES = `HSQ_SCROLL_S * `HSQ_CLK_HZ
)
(
  input wire clk,
  input wire sys_rst,
  input wire ce,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire measStrobe,
  input wire [15:0] voltage,
  input wire [15:0] current,
  input wire measError,
  output wire stabilizedLamp,
  output reg noInputLamp,
  output reg warnAlarm,
  output reg critAlarm,
  output reg lastAlarm,
  output reg [2:0] dispSel
);
  localparam [1:0] ST_WAIT = 2'b01;
  localparam [1:0] ST_STABILIZED_LAMP = 2'b10;

  // rate in 0.1 % units: a/b*1000-1000, saturated at the top
  function [15:0] rate;
    input [15:0] a;
    input [15:0] b;
    reg [31:0] q;
    begin
      q = 32'h00000000;
      if (b != 16'h0000)
        q = ({16'h0000, a} * `HSQ_RATE_ONE) / {16'h0000, b};
      if (q > `HSQ_RATE_CAP)
        q = `HSQ_RATE_CAP;
      rate = q[15:0] - 16'd1000;
    end
  endfunction

  function [15:0] absv;
    input [15:0] v;
    begin
      absv = v[15] ? (16'h0000 - v) : v;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  wire wrEn;
  wire [7:0] wrAddr;
  wire [31:0] wrData;
  wire [3:0] wrStrb;
  reg [31:0] rdData;
  reg rdOk;
  reg wrOk;

  reg [31:0] ctrl_r;
  reg [31:0] counts_r;
  reg [31:0] vlim_r;
  reg [31:0] ilim_r;
  reg [31:0] pband_r;
  reg [15:0] temp_r;
  reg [31:0] tband_r;
  reg [31:0] dev_r;
  reg [31:0] levels_r;
  reg [31:0] lastlvl_r;

  reg [1:0] state_r;
  reg [15:0] res_r;
  reg [15:0] pwr_r;
  reg [15:0] prevPwr_r;
  reg [15:0] refRes_r;
  reg refValid_r;
  reg [15:0] lastRes_r;
  reg [7:0] lastCnt_r;
  reg cond3_r;
  reg cond4_r;
  reg stepD_r;
  reg [31:0] scrollCnt_r;

  wire tempMode = ctrl_r[`HSQ_CTRL_TEMPMODE];
  wire [7:0] pwrMa = counts_r[7:0];
  wire [7:0] resMa = counts_r[15:8];
  wire [7:0] bigMa = (pwrMa > resMa) ? pwrMa : resMa;
  wire [7:0] target = tempMode ? resMa : bigMa;

  // resistance = V*256/I, power = V*I/256, both saturated to 16 bits
  wire [31:0] resFull = (current == 16'h0000) ? 32'h0000FFFF :
    ({voltage, 8'h00} / {16'h0000, current});
  wire [31:0] pwrFull = voltage * current;
  wire [15:0] resNow = (resFull[31:16] != 16'h0000) ? 16'hFFFF : resFull[15:0];
  wire [15:0] pwrNow = (pwrFull[31:24] != 8'h00) ? 16'hFFFF : pwrFull[23:8];

  wire [15:0] refRate = refValid_r ? rate(res_r, refRes_r) : 16'h0000;
  wire [15:0] lastRate = rate(res_r, lastRes_r);
  wire [15:0] devRate = rate(resNow, dev_r[15:0]);

  wire pwrIn = (prevPwr_r != 16'h0000) &&
    (absv(rate(pwrNow, prevPwr_r)) <= pband_r[15:0]);
  wire tempIn = ($signed(temp_r) >= $signed(tband_r[15:0])) &&
    ($signed(temp_r) <= $signed(tband_r[31:16]));
  wire devIn = absv(devRate) <= dev_r[31:16];
  wire c1In = tempMode ? tempIn : pwrIn;
  wire cond1;
  wire cond2;
  wire allOk = cond1 && cond2 && cond3_r && cond4_r && !measError;

  hsq_run_counter u_cond1
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .step(measStrobe),
    .inBand(c1In),
    .target(target),
    .met(cond1)
  );

  hsq_run_counter u_cond2
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .step(measStrobe),
    .inBand(devIn),
    .target(target),
    .met(cond2)
  );

  hsq_axil_port u_bus
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrOk(wrOk),
    .rdData(rdData),
    .rdOk(rdOk)
  );

  assign stabilizedLamp = (state_r == ST_STABILIZED_LAMP);

  always @*
  begin
    case (wrAddr)
      `HSQ_ADDR_CTRL, `HSQ_ADDR_COUNTS, `HSQ_ADDR_VLIM, `HSQ_ADDR_ILIM,
      `HSQ_ADDR_PBAND, `HSQ_ADDR_TEMP, `HSQ_ADDR_TBAND, `HSQ_ADDR_DEV,
      `HSQ_ADDR_LEVELS, `HSQ_ADDR_LASTLVL: wrOk = 1'b1;
      default: wrOk = 1'b0;
    endcase
  end

  always @*
  begin
    rdOk = 1'b1;
    case (s_axi_araddr)
      `HSQ_ADDR_CTRL: rdData = ctrl_r;
      `HSQ_ADDR_COUNTS: rdData = counts_r;
      `HSQ_ADDR_VLIM: rdData = vlim_r;
      `HSQ_ADDR_ILIM: rdData = ilim_r;
      `HSQ_ADDR_PBAND: rdData = pband_r;
      `HSQ_ADDR_TEMP: rdData = {{16{temp_r[15]}}, temp_r};
      `HSQ_ADDR_TBAND: rdData = tband_r;
      `HSQ_ADDR_DEV: rdData = dev_r;
      `HSQ_ADDR_LEVELS: rdData = levels_r;
      `HSQ_ADDR_LASTLVL: rdData = lastlvl_r;
      `HSQ_ADDR_STATUS: rdData = {23'h000000, refValid_r, dispSel, lastAlarm,
        critAlarm, warnAlarm, noInputLamp, stabilizedLamp};
      `HSQ_ADDR_RATES: rdData = {lastRate, refRate};
      `HSQ_ADDR_MEAS: rdData = {pwr_r, res_r};
      default:
      begin
        rdData = 32'h00000000;
        rdOk = 1'b0;
      end
    endcase
  end

  // register writes; out-of-range temperatures are clamped, not refused
  reg [31:0] tempW;
  always @*
  begin
    tempW = merge({{16{temp_r[15]}}, temp_r}, wrData, wrStrb);
    if ($signed(tempW[15:0]) < `HSQ_TEMP_MIN)
      tempW[15:0] = 16'hF831;
    else if ($signed(tempW[15:0]) > `HSQ_TEMP_MAX)
      tempW[15:0] = 16'h270F;
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_r <= 32'h00000000;
      counts_r <= `HSQ_RST_COUNTS;
      vlim_r <= 32'h00000000;
      ilim_r <= 32'h00000000;
      pband_r <= `HSQ_RST_PBAND;
      temp_r <= 16'h0000;
      tband_r <= 32'h00000000;
      dev_r <= `HSQ_RST_DEV;
      levels_r <= `HSQ_RST_LEVELS_W;
      lastlvl_r <= `HSQ_RST_LASTLVL;
    end
    else if (ce && wrEn)
    begin
      case (wrAddr)
        `HSQ_ADDR_CTRL: ctrl_r <= merge(ctrl_r, wrData, wrStrb) & 32'h00000003;
        `HSQ_ADDR_COUNTS: counts_r <= merge(counts_r, wrData, wrStrb) & 32'h0000FFFF;
        `HSQ_ADDR_VLIM: vlim_r <= merge(vlim_r, wrData, wrStrb) & 32'h0000FFFF;
        `HSQ_ADDR_ILIM: ilim_r <= merge(ilim_r, wrData, wrStrb) & 32'h0000FFFF;
        `HSQ_ADDR_PBAND: pband_r <= merge(pband_r, wrData, wrStrb) & 32'h0000FFFF;
        `HSQ_ADDR_TEMP: temp_r <= tempW[15:0];
        `HSQ_ADDR_TBAND: tband_r <= merge(tband_r, wrData, wrStrb);
        `HSQ_ADDR_DEV: dev_r <= merge(dev_r, wrData, wrStrb);
        `HSQ_ADDR_LEVELS: levels_r <= merge(levels_r, wrData, wrStrb);
        `HSQ_ADDR_LASTLVL: lastlvl_r <= merge(lastlvl_r, wrData, wrStrb) & 32'h0000FFFF;
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // measurement pipeline: values taken at the strobe, decisions one cycle later
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      res_r <= 16'h0000;
      pwr_r <= 16'h0000;
      prevPwr_r <= 16'h0000;
      lastRes_r <= 16'h0000;
      lastCnt_r <= 8'h00;
      cond3_r <= 1'b0;
      cond4_r <= 1'b0;
      noInputLamp <= 1'b1;
      stepD_r <= 1'b0;
    end
    else if (ce)
    begin
      stepD_r <= measStrobe;
      if (measStrobe)
      begin
        res_r <= resNow;
        pwr_r <= pwrNow;
        prevPwr_r <= pwrNow;
        cond3_r <= (voltage >= vlim_r[15:0]);
        cond4_r <= (current >= ilim_r[15:0]);
        noInputLamp <= (voltage == 16'h0000) || (current == 16'h0000);
        // last-rate base: resistance one averaging window earlier
        if (lastCnt_r + 8'h01 >= resMa)
        begin
          lastCnt_r <= 8'h00;
          lastRes_r <= res_r;
        end
        else
          lastCnt_r <= lastCnt_r + 8'h01;
      end
    end
  end

  // operating state machine, reference capture and alarm evaluation
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_WAIT;
      refRes_r <= 16'h0000;
      refValid_r <= 1'b0;
      warnAlarm <= 1'b0;
      critAlarm <= 1'b0;
      lastAlarm <= 1'b0;
    end
    else if (ce)
    begin
      if (measError)
        state_r <= ST_WAIT;
      else if (stepD_r)
      begin
        case (state_r)
          ST_WAIT:
          begin
            if (allOk)
            begin
              state_r <= ST_STABILIZED_LAMP;
              if (!refValid_r)
              begin
                refRes_r <= res_r;
                refValid_r <= 1'b1;
              end
            end
          end
          ST_STABILIZED_LAMP:
          begin
            if (!allOk)
              state_r <= ST_WAIT;
          end
          default: state_r <= ST_WAIT;
        endcase
      end
      if (state_r != ST_STABILIZED_LAMP)
      begin
        warnAlarm <= 1'b0;
        critAlarm <= 1'b0;
        lastAlarm <= 1'b0;
      end
      else if (stepD_r)
      begin
        warnAlarm <= $signed(refRate) >= $signed(levels_r[15:0]);
        critAlarm <= $signed(refRate) >= $signed(levels_r[31:16]);
        lastAlarm <= $signed(lastRate) >= $signed(lastlvl_r[15:0]);
      end
    end
  end

  // display auto scroll; long count is a parameter so simulation can shorten it
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      scrollCnt_r <= 32'h00000000;
      dispSel <= 3'h0;
    end
    else if (ce)
    begin
      if (!ctrl_r[`HSQ_CTRL_SCROLL])
        scrollCnt_r <= 32'h00000000;
      else if (scrollCnt_r >= SCROLL_CYCLES - 32'h00000001)
      begin
        scrollCnt_r <= 32'h00000000;
        dispSel <= (dispSel == `HSQ_SCROLL_ITEMS - 1) ? 3'h0 : dispSel + 3'h1;
      end
      else
        scrollCnt_r <= scrollCnt_r + 32'h00000001;
    end
  end
endmodule // hsq_qualifier

// [testbench/hsq_qualifier_monitor.sv]
// checker of lamp, alarm, scroll and bus answer relations at the qualifier ports
// assumes it is bound into hsq_qualifier and sees only its ports
`timescale 1ns/1ps
module hsq_qualifier_monitor
#(
  parameter [31:0] SCROLL_CYCLES = 32'h00000014
)
(
  input wire clk,
  input wire sys_rst,
  input wire ce,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire measStrobe,
  input wire [15:0] voltage,
  input wire [15:0] current,
  input wire measError,
  input wire stabilizedLamp,
  input wire noInputLamp,
  input wire warnAlarm,
  input wire critAlarm,
  input wire lastAlarm,
  input wire [2:0] dispSel
);
  default clocking mcb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // two idle cycles let the alarm registers follow the state
  quiet_wait_a: assert property (
    !stabilizedLamp [*2] |-> !(warnAlarm || critAlarm || lastAlarm)) else $error("alarm in wait");
  err_wait_a: assert property (
    ce && measError |=> !stabilizedLamp) else $error("error kept stabilized");
  entry_cause_a: assert property (
    $rose(stabilizedLamp) |-> ($past(measStrobe, 2) || $past(measStrobe, 3)) && !$past(measError))
    else $error("entry without strobe");
  exit_cause_a: assert property (
    $fell(stabilizedLamp) |-> $past(measError) || $past(measStrobe, 2) || $past(measStrobe, 3))
    else $error("exit without cause");
  no_input_on_a: assert property (
    ce && measStrobe && (voltage == 16'h0000 || current == 16'h0000) |=> noInputLamp)
    else $error("no-input lamp dark");
  no_input_off_a: assert property (
    ce && measStrobe && voltage != 16'h0000 && current != 16'h0000 |=> !noInputLamp)
    else $error("no-input lamp lit");
  scroll_step_a: assert property (
    $changed(dispSel) |-> dispSel == (($past(dispSel) == 3'h5) ? 3'h0 : $past(dispSel) + 3'h1))
    else $error("bad display step");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  read_answer_a: assert property (
    ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  cover property ($rose(stabilizedLamp));
  cover property ($rose(warnAlarm));
  cover property ($rose(critAlarm));
endmodule // hsq_qualifier_monitor

bind hsq_qualifier hsq_qualifier_monitor #(.SCROLL_CYCLES(SCROLL_CYCLES)) mon
(
  .clk, .sys_rst, .ce, .s_axi_arvalid, .s_axi_arready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .measStrobe, .voltage, .current, .measError, .stabilizedLamp,
  .noInputLamp, .warnAlarm, .critAlarm, .lastAlarm, .dispSel
);

// [testbench/hsq_host_model.sv]
// host model: AXI4-Lite master, one write or read at a time, writes temperature
// assumes a slave on the same clock; the bench calls its tasks
`timescale 1ns/1ps
module hsq_host_model
(
  input wire clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output logic s_axi_rready
);
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // whole words only; each half released on the edge it is taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // bready raised only once bvalid shows, so the slave must hold its answer
    while (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1)
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && s_axi_bready !== 1'b1)
        s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (s_axi_rvalid !== 1'b1)
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // hsq_host_model

// [testbench/tb_heater_stabilization_qualifier.sv]
// bench for the heater stabilization qualifier: registers, qualification, alarms, scroll
// assumes the host model owns the register bus and the bench drives measurements
`timescale 1ns/1ps
`include "hsq_consts.vh"
`define HSQ_CHECK(got, exp) begin testsRun++; if ((got) !== (exp)) begin nFail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_heater_stabilization_qualifier;
  localparam logic [31:0] SCROLL = 32'h00000014;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic ce = 1'b1;
  logic measStrobe = 1'b0;
  logic measError = 1'b0;
  logic [15:0] voltage = 16'h0000;
  logic [15:0] current = 16'h0000;
  logic [31:0] seed = 32'h00000048;
  logic [31:0] rdVal;
  logic [1:0] resp;
  logic [15:0] rate;
  logic [2:0] lastSel;
  int nFail = 0;
  int testsRun = 0;
  int cycles = 0;
  int t;
  int n;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire stabilizedLamp, noInputLamp, warnAlarm, critAlarm, lastAlarm;
  wire [2:0] dispSel;
  logic [7:0] rstAddr [5] = '{`HSQ_ADDR_COUNTS, `HSQ_ADDR_PBAND, `HSQ_ADDR_DEV,
    `HSQ_ADDR_LEVELS, `HSQ_ADDR_LASTLVL};
  logic [31:0] rstVal [5] = '{`HSQ_RST_COUNTS, `HSQ_RST_PBAND, `HSQ_RST_DEV,
    `HSQ_RST_LEVELS_W, `HSQ_RST_LASTLVL};

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  hsq_qualifier #(.SCROLL_CYCLES(SCROLL)) DUT
  (
    .clk, .sys_rst(sysRst), .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .measStrobe, .voltage, .current, .measError, .stabilizedLamp, .noInputLamp,
    .warnAlarm, .critAlarm, .lastAlarm, .dispSel
  );
  hsq_host_model HOST
  (
    .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  function automatic logic [31:0] nextRand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] clampTemp(input int v);
    return 16'((v > `HSQ_TEMP_MAX) ? `HSQ_TEMP_MAX : (v < `HSQ_TEMP_MIN) ? `HSQ_TEMP_MIN : v);
  endfunction
  // resistance scaled by 256, rate in 0.1 percent against a 1000 reference
  function automatic logic [15:0] refRate(input int v, input int i);
    return 16'((v * 256 / i) * 1000 / 1000 - 1000);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    HOST.axiWrite(a, d, resp);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    HOST.axiRead(a, rdVal, resp);
    `HSQ_CHECK(rdVal, e)
    `HSQ_CHECK(resp, er)
  endtask
  // random gap keeps strobes at least two cycles apart
  task automatic strobe(input logic [15:0] v, input logic [15:0] i);
    @(posedge clk);
    voltage <= v;
    current <= i;
    measStrobe <= 1'b1;
    @(posedge clk);
    measStrobe <= 1'b0;
    repeat (3 + nextRand() % 4) @(posedge clk);
  endtask
  task automatic settle(input logic [15:0] v, input logic [15:0] i);
    for (int k = 0; k < 8 && stabilizedLamp !== 1'b1; k++)
      strobe(v, i);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      nFail++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    sysRst <= 1'b0;
    `HSQ_CHECK({stabilizedLamp, noInputLamp, dispSel}, 5'h08)
    for (int k = 0; k < 5; k++)
      rdChk(rstAddr[k], rstVal[k], `HSQ_RESP_OKAY);
    rdChk(8'h3C, 32'h00000000, `HSQ_RESP_SLVERR);
    wr(`HSQ_ADDR_STATUS, 32'hFFFFFFFF);
    `HSQ_CHECK(resp, `HSQ_RESP_SLVERR)
    for (int k = 0; k < 3; k++)
    begin
      t = (k == 0) ? 20000 : (k == 1) ? -5000 : int'(nextRand() % 12000) - 2000;
      wr(`HSQ_ADDR_TEMP, 32'(t));
      HOST.axiRead(`HSQ_ADDR_TEMP, rdVal, resp);
      `HSQ_CHECK(rdVal[15:0], clampTemp(t))
    end
    wr(`HSQ_ADDR_COUNTS, 32'h00000203);
    wr(`HSQ_ADDR_VLIM, 32'h0000000A);
    wr(`HSQ_ADDR_ILIM, 32'h0000000A);
    wr(`HSQ_ADDR_PBAND, 32'h00000064);
    wr(`HSQ_ADDR_DEV, 32'h006403E8);
    for (int k = 1; k <= 4; k++)
    begin
      strobe(16'h03E8, 16'h0100);
      `HSQ_CHECK(stabilizedLamp, k == 4)
    end
    `HSQ_CHECK(noInputLamp, 1'b0)
    for (int k = 0; k < 2; k++)
    begin
      strobe(16'h03E8, 16'(246 - 6 * k));
      rate = refRate(1000, 246 - 6 * k);
      HOST.axiRead(`HSQ_ADDR_RATES, rdVal, resp);
      `HSQ_CHECK(rdVal[15:0], rate)
      `HSQ_CHECK({warnAlarm, critAlarm, lastAlarm}, {rate >= 16'h001E, rate >= 16'h0032, 1'b0})
      `HSQ_CHECK(stabilizedLamp, 1'b1)
    end
    for (int k = 0; k < 3; k++)
    begin
      settle(16'h03E8, 16'h00F0);
      // alarms are first judged on the strobe after entry
      strobe(16'h03E8, 16'h00F0);
      `HSQ_CHECK(critAlarm, 1'b1)
      if (k == 2)
      begin
        @(posedge clk);
        measError <= 1'b1;
        @(posedge clk);
        measError <= 1'b0;
        repeat (2) @(posedge clk);
      end
      else
        strobe((k == 0) ? 16'h0005 : 16'h03E8, (k == 0) ? 16'h00F0 : 16'h0005);
      `HSQ_CHECK({stabilizedLamp, critAlarm}, 2'h0)
    end
    strobe(16'h0000, 16'h0000);
    `HSQ_CHECK(noInputLamp, 1'b1)
    wr(`HSQ_ADDR_CTRL, 32'h00000001);
    wr(`HSQ_ADDR_TBAND, 32'h01F40064);
    wr(`HSQ_ADDR_TEMP, 32'h0000012C);
    settle(16'h03E8, 16'h00F0);
    `HSQ_CHECK(stabilizedLamp, 1'b1)
    for (int k = 0; k < 3; k++)
    begin
      wr(`HSQ_ADDR_TEMP, (k == 0) ? 32'h00000258 : 32'h0000012C);
      strobe(16'h03E8, 16'h00F0);
      `HSQ_CHECK(stabilizedLamp, k == 2)
    end
    wr(`HSQ_ADDR_CTRL, 32'h00000003);
    for (int k = 0; k < 2; k++)
    begin
      lastSel = dispSel;
      for (n = 0; n < 100 && dispSel === lastSel; n++)
        @(posedge clk);
    end
    `HSQ_CHECK(n, int'(SCROLL))
    // a low clock enable must freeze the display step
    lastSel = dispSel;
    ce <= 1'b0;
    repeat (45) @(posedge clk);
    `HSQ_CHECK(dispSel, lastSel)
    ce <= 1'b1;
    end_of_test();
  end
endmodule // tb_heater_stabilization_qualifier
